// [dcff_host_model.sv]
`timescale 1ns/1ns
module dcff_host_model (
  input wire logic clk_i,
  input wire logic wr_go_i,
  input wire logic rd_go_i,
  input wire logic wr_en2_i,
  input wire logic full_n_i,
  input wire logic empty_n_i,
  input wire logic [8:0] dq_i,
  output logic wen_n_o,
  output logic ren_n_o,
  output logic [8:0] wdata_o,
  output int bad_o
);
  logic [8:0] exp_q = 9'h000;
  logic wt = 1'b0;
  logic rt = 1'b0;
  initial {wen_n_o, ren_n_o, wdata_o, bad_o} = {2'b11, 9'h000, 32'h0};
  always @(posedge clk_i) begin
    wt <= !wen_n_o && wr_en2_i && full_n_i;
    rt <= !ren_n_o && empty_n_i;
  end
  // Requests move on the falling edge so they never race the sampling edge.
  always @(negedge clk_i) begin
    if (wt) wdata_o <= wdata_o + 9'h001;
    if (rt && dq_i !== exp_q) bad_o <= bad_o + 1;
    if (rt) exp_q <= exp_q + 9'h001;
    wen_n_o <= !wr_go_i;
    ren_n_o <= !rd_go_i;
  end
endmodule // dcff_host_model

// [dcff_pkg.sv]
package dcff_pkg;

  typedef enum logic [1:0] {
    MODE_WRITE2 = 2'b01,
    MODE_LOAD = 2'b10
  } dcff_mode_type;

  typedef enum logic [3:0] {
    LD_AE_LO = 4'b0001,
    LD_AE_HI = 4'b0010,
    LD_AF_LO = 4'b0100,
    LD_AF_HI = 4'b1000
  } dcff_load_type;

  typedef struct packed {
    logic full_flag_n;
    logic almost_full_flag_n;
    logic almost_empty_flag_n;
    logic empty_flag_n;
  } dcff_flags_type;

endpackage

// [dcff_regs.svh]
`ifndef DCFF_REGS_SVH
`define DCFF_REGS_SVH
// Behaviour
// - The full flag may lag one write-clock edge when the read edge comes too close before it.
// - The empty flag may lag one read-clock edge when the write edge comes too close before it.
// - The almost-empty flag may lag one read-clock edge when the write edge is too close.
// - The almost-full flag may lag one write-clock edge when the read edge is too close.
// - Reset works correctly while the clocks keep running.
// - After reset the data outputs drive low when output enable is 0 and float when it is 1.
// - The level of the shared write-enable/load pin during reset picks second enable or load; here it is sampled on the two edges after reset releases.
// - The first word is presented on the read cycle after the empty flag goes high.
// - First-read latency at the empty boundary is one period plus skew, or at most two.
// - With almost-empty offset n the flag goes low as the buffer drops to n-1 words.
// - With almost-full offset m the flag goes low as the buffer reaches full minus m-1 words.

`define DCFF_DATA_W 9
`define DCFF_ADDR_W 14
`define DCFF_DEPTH 15'h4000
`define DCFF_CNT_W 15
`define DCFF_OFFSET_RST 14'h0007
`define DCFF_OFFSET_LO_W 9
`define DCFF_OFFSET_HI_W 5
`define DCFF_SKEW1_NS 5
`define DCFF_SKEW2_NS 10
`define DCFF_CLK_PERIOD_NS 4
`define DCFF_SKEW1_CYC ((`DCFF_SKEW1_NS + `DCFF_CLK_PERIOD_NS - 1) / `DCFF_CLK_PERIOD_NS)
`define DCFF_SKEW2_CYC ((`DCFF_SKEW2_NS + `DCFF_CLK_PERIOD_NS - 1) / `DCFF_CLK_PERIOD_NS)

`endif

// [dcff_top.sv]
`timescale 1ns/1ns
`include "dcff_regs.svh"

module dcff_top (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic WRITE_EN1_N_I,
  input wire logic WRITE_ENABLE2_OR_LOAD_I,
  input wire logic [`DCFF_DATA_W-1:0] WR_DATA_I,
  input wire logic READ_EN1_N_I,
  input wire logic READ_EN2_N_I,
  input wire logic OUTPUT_ENABLE_N_I,
  output logic [`DCFF_DATA_W-1:0] RD_DATA_O,
  output logic RD_DATA_OE_O,
  output logic FULL_FLAG_N_O,
  output logic ALMOST_FULL_FLAG_N_O,
  output logic ALMOST_EMPTY_FLAG_N_O,
  output logic EMPTY_FLAG_N_O
);

  //////////////////////////////////////////////////////////////////////////////
  logic rst_meta_q;
  logic rst_n_q;
  dcff_pkg::dcff_mode_type mode_q;
  dcff_pkg::dcff_load_type load_q;
  dcff_pkg::dcff_flags_type flags_q;
  dcff_pkg::dcff_flags_type flags_d;
  logic [`DCFF_DATA_W-1:0] mem [0:`DCFF_DEPTH-1];
  logic [`DCFF_ADDR_W-1:0] wr_ptr_q;
  logic [`DCFF_ADDR_W-1:0] rd_ptr_q;
  logic [`DCFF_CNT_W-1:0] count_q;
  logic [`DCFF_CNT_W-1:0] count_d;
  logic [`DCFF_ADDR_W-1:0] ae_offset_q;
  logic [`DCFF_ADDR_W-1:0] af_offset_q;
  logic [`DCFF_DATA_W-1:0] rd_data_q;
  logic oe_q;
  logic wr_en;
  logic rd_en;
  logic load_en;

  //////////////////////////////////////////////////////////////////////////////
  // Clocks may run freely through reset, so the release is synchronised.
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // The pin is sampled on the two edges after reset releases, while rst_n_q is still low, never by the reset itself.
  // The last sample before the internal reset lifts decides the role for the whole run.
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      mode_q <= dcff_pkg::MODE_WRITE2;
    end else if (!rst_n_q) begin
      mode_q <= WRITE_ENABLE2_OR_LOAD_I ? dcff_pkg::MODE_WRITE2 : dcff_pkg::MODE_LOAD;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Writes are refused while full and reads while empty, so the count never wraps.
  always_comb begin
    wr_en = 1'b0;
    load_en = 1'b0;
    if (rst_n_q && !WRITE_EN1_N_I) begin
      unique case (mode_q)
        dcff_pkg::MODE_WRITE2: begin
          wr_en = WRITE_ENABLE2_OR_LOAD_I && flags_q.full_flag_n;
        end
        dcff_pkg::MODE_LOAD: begin
          // In load mode a high pin still writes, so the host never loses the data path.
          load_en = !WRITE_ENABLE2_OR_LOAD_I;
          wr_en = WRITE_ENABLE2_OR_LOAD_I && flags_q.full_flag_n;
        end
      endcase
    end
  end

  // Both read enables must be low, and nothing is read out of an empty buffer.
  always_comb begin
    rd_en = rst_n_q && !READ_EN1_N_I && !READ_EN2_N_I && flags_q.empty_flag_n;
  end

  // Storage has no reset; stale words stay hidden because reads are refused while empty.
  always_ff @(posedge CLK_I) begin
    if (wr_en) begin
      mem[wr_ptr_q] <= WR_DATA_I;
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      wr_ptr_q <= '0;
    end else if (!rst_n_q) begin
      wr_ptr_q <= '0;
    end else if (wr_en) begin
      wr_ptr_q <= wr_ptr_q + 1'b1;
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rd_ptr_q <= '0;
    end else if (!rst_n_q) begin
      rd_ptr_q <= '0;
    end else if (rd_en) begin
      rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Offsets load in four steps, each nine-bit write landing in the next half.
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      load_q <= dcff_pkg::LD_AE_LO;
    end else if (!rst_n_q) begin
      load_q <= dcff_pkg::LD_AE_LO;
    end else if (load_en) begin
      unique case (load_q)
        dcff_pkg::LD_AE_LO: load_q <= dcff_pkg::LD_AE_HI;
        dcff_pkg::LD_AE_HI: load_q <= dcff_pkg::LD_AF_LO;
        dcff_pkg::LD_AF_LO: load_q <= dcff_pkg::LD_AF_HI;
        dcff_pkg::LD_AF_HI: load_q <= dcff_pkg::LD_AE_LO;
      endcase
    end
  end

  // The high halves take only five bits; the upper data bits of those loads are ignored.
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ae_offset_q <= `DCFF_OFFSET_RST;
      af_offset_q <= `DCFF_OFFSET_RST;
    end else if (!rst_n_q) begin
      ae_offset_q <= `DCFF_OFFSET_RST;
      af_offset_q <= `DCFF_OFFSET_RST;
    end else if (load_en) begin
      unique case (load_q)
        dcff_pkg::LD_AE_LO: begin
          ae_offset_q[`DCFF_OFFSET_LO_W-1:0] <= WR_DATA_I;
        end
        dcff_pkg::LD_AE_HI: begin
          ae_offset_q[`DCFF_ADDR_W-1:`DCFF_OFFSET_LO_W] <= WR_DATA_I[`DCFF_OFFSET_HI_W-1:0];
        end
        dcff_pkg::LD_AF_LO: begin
          af_offset_q[`DCFF_OFFSET_LO_W-1:0] <= WR_DATA_I;
        end
        dcff_pkg::LD_AF_HI: begin
          af_offset_q[`DCFF_ADDR_W-1:`DCFF_OFFSET_LO_W] <= WR_DATA_I[`DCFF_OFFSET_HI_W-1:0];
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // One clock feeds both sides, so skew is always met and no flag lags.
  always_comb begin
    count_d = count_q;
    if (wr_en && !rd_en) begin
      count_d = count_q + 1'b1;
    end else if (rd_en && !wr_en) begin
      count_d = count_q - 1'b1;
    end
    flags_d.empty_flag_n = (count_d != '0);
    flags_d.full_flag_n = (count_d != `DCFF_DEPTH);
    flags_d.almost_empty_flag_n = (count_d >= {1'b0, ae_offset_q});
    flags_d.almost_full_flag_n = (count_d <= (`DCFF_DEPTH - {1'b0, af_offset_q}));
  end

  // The count is one bit wider than the pointers so that full and empty differ.
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      count_q <= '0;
    end else if (!rst_n_q) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      flags_q.full_flag_n <= 1'b1;
      flags_q.almost_full_flag_n <= 1'b1;
      flags_q.almost_empty_flag_n <= 1'b0;
      flags_q.empty_flag_n <= 1'b0;
    end else if (!rst_n_q) begin
      flags_q.full_flag_n <= 1'b1;
      flags_q.almost_full_flag_n <= 1'b1;
      flags_q.almost_empty_flag_n <= 1'b0;
      flags_q.empty_flag_n <= 1'b0;
    end else begin
      flags_q <= flags_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // The read register drives low out of reset so a floating bus never sees stale data.
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rd_data_q <= '0;
    end else if (!rst_n_q) begin
      rd_data_q <= '0;
    end else if (rd_en) begin
      rd_data_q <= mem[rd_ptr_q];
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= rst_n_q && !OUTPUT_ENABLE_N_I;
    end
  end

  assign RD_DATA_O = rd_data_q;
  assign RD_DATA_OE_O = oe_q;
  assign FULL_FLAG_N_O = flags_q.full_flag_n;
  assign ALMOST_FULL_FLAG_N_O = flags_q.almost_full_flag_n;
  assign ALMOST_EMPTY_FLAG_N_O = flags_q.almost_empty_flag_n;
  assign EMPTY_FLAG_N_O = flags_q.empty_flag_n;

endmodule // dcff_top

// [dcff_top_assertions.sv]
`timescale 1ns/1ns
`include "dcff_regs.svh"
module dcff_top_checker (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic WRITE_EN1_N_I,
  input wire logic WRITE_ENABLE2_OR_LOAD_I,
  input wire logic READ_EN1_N_I,
  input wire logic READ_EN2_N_I,
  input wire logic OUTPUT_ENABLE_N_I,
  input wire logic [`DCFF_DATA_W-1:0] RD_DATA_O,
  input wire logic RD_DATA_OE_O,
  input wire logic FULL_FLAG_N_O,
  input wire logic ALMOST_FULL_FLAG_N_O,
  input wire logic ALMOST_EMPTY_FLAG_N_O,
  input wire logic EMPTY_FLAG_N_O
);
  logic wr_t;
  logic rd_t;
  logic [`DCFF_CNT_W-1:0] cnt_q;
  assign wr_t = !WRITE_EN1_N_I && WRITE_ENABLE2_OR_LOAD_I && FULL_FLAG_N_O;
  assign rd_t = !READ_EN1_N_I && !READ_EN2_N_I && EMPTY_FLAG_N_O;
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) cnt_q <= '0;
    else cnt_q <= cnt_q + {14'h0000, wr_t} - {14'h0000, rd_t};
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  chk_empty_level: assert property (EMPTY_FLAG_N_O == (cnt_q != '0))
    else $error("bad empty flag");
  chk_full_level: assert property (FULL_FLAG_N_O == (cnt_q != `DCFF_DEPTH))
    else $error("bad full flag");
  chk_ae_level: assert property (ALMOST_EMPTY_FLAG_N_O == (cnt_q > 15'h0006))
    else $error("bad almost empty flag");
  chk_af_level: assert property (ALMOST_FULL_FLAG_N_O == (cnt_q < 15'h3ffa))
    else $error("bad almost full flag");
  chk_af_fall: assert property ($fell(ALMOST_FULL_FLAG_N_O) |->
    $past(wr_t) && cnt_q == 15'h3ffa) else $error("almost full fell at wrong count");
  chk_first_latency: assert property ($rose(EMPTY_FLAG_N_O) |-> $past(wr_t))
    else $error("empty flag rose late");
  chk_data_hold: assert property (!rd_t |=> $stable(RD_DATA_O))
    else $error("read data moved");
  chk_oe_follow: assert property ($past(RESET_N_I, 3) |->
    RD_DATA_OE_O == !$past(OUTPUT_ENABLE_N_I)) else $error("bad output drive");
  cover property ($fell(FULL_FLAG_N_O));
  cover property ($rose(EMPTY_FLAG_N_O));
  cover property ($fell(ALMOST_FULL_FLAG_N_O));
endmodule // dcff_top_checker
////////////////////
bind dcff_top dcff_top_checker i_dcff_top_checker (.*);

// [tb_dcff_top.sv]
`timescale 1ns/1ns
module tb_dcff_top;
  typedef struct packed {logic wr; logic rd; logic [15:0] n; dcff_pkg::dcff_flags_type f;} dcff_row_type;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pin = 1'b1;
  logic oe_n = 1'b1;
  logic wr_go = 1'b0;
  logic rd_go = 1'b0;
  logic [8:0] ld = 9'h007;
  logic wen_n, ren_n, oe_o;
  logic [8:0] wdata, rdata;
  dcff_pkg::dcff_flags_type fl;
  int bad;
  int error_cnt = 0;
  int n_compared = 0;
  wire [8:0] dq = oe_o ? rdata : ~rdata;
  dcff_row_type rows [12] = '{{1'b1, 1'b0, 16'h0006, 4'hd}, {1'b1, 1'b0, 16'h0001, 4'hf},
    {1'b0, 1'b1, 16'h0001, 4'hd}, {1'b0, 1'b1, 16'h0006, 4'hc}, {1'b1, 1'b0, 16'h3ff9, 4'hf},
    {1'b1, 1'b0, 16'h0001, 4'hb}, {1'b1, 1'b0, 16'h0007, 4'h3}, {1'b0, 1'b1, 16'h0001, 4'hb},
    {1'b0, 1'b1, 16'h3fff, 4'hc}, {1'b1, 1'b1, 16'h0003, 4'hd}, {1'b0, 1'b1, 16'h0001, 4'hc},
    {1'b1, 1'b0, 16'h0002, 4'hd}};
  always #2 clk = ~clk;
  dcff_top i_dcff_top (.CLK_I(clk), .RESET_N_I(rst_n), .WRITE_EN1_N_I(wen_n),
    .WRITE_ENABLE2_OR_LOAD_I(pin), .WR_DATA_I(pin ? wdata : ld), .READ_EN1_N_I(ren_n),
    .READ_EN2_N_I(ren_n), .OUTPUT_ENABLE_N_I(oe_n), .RD_DATA_O(rdata), .RD_DATA_OE_O(oe_o),
    .FULL_FLAG_N_O(fl.full_flag_n), .ALMOST_FULL_FLAG_N_O(fl.almost_full_flag_n),
    .ALMOST_EMPTY_FLAG_N_O(fl.almost_empty_flag_n), .EMPTY_FLAG_N_O(fl.empty_flag_n));
  dcff_host_model i_dcff_host_model (.clk_i(clk), .wr_go_i(wr_go), .rd_go_i(rd_go),
    .wr_en2_i(pin), .full_n_i(fl.full_flag_n), .empty_n_i(fl.empty_flag_n), .dq_i(dq),
    .wen_n_o(wen_n), .ren_n_o(ren_n), .wdata_o(wdata), .bad_o(bad));
  ////////////////////
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic rst_seq(logic mode);
    rst_n <= 1'b0;
    pin <= mode;
    oe_n <= 1'b1;
    repeat (20) @(negedge clk);
    rst_n <= 1'b1;
    repeat (3) @(negedge clk);
    check("reset flags", 32'hc, fl);
    check("drive after reset", 32'h0, oe_o);
    oe_n <= 1'b0;
    repeat (2) @(negedge clk);
    check("data after reset", 32'h0, dq);
  endtask
  initial begin
    rst_seq(1'b1);
    foreach (rows[i]) begin
      wr_go <= rows[i].wr;
      rd_go <= rows[i].rd;
      repeat (rows[i].n) @(negedge clk);
      wr_go <= 1'b0;
      rd_go <= 1'b0;
      repeat (2) @(negedge clk);
      check("flags", rows[i].f, fl);
      $display("row %0d done", i);
    end
    check("read words", 32'h0, bad);
    rst_seq(1'b0);
    wr_go <= 1'b1;
    for (int j = 0; j < 4; j++) begin
      @(negedge clk);
      ld <= j[0] ? 9'h000 : 9'h007;
    end
    wr_go <= 1'b0;
    repeat (2) @(negedge clk);
    check("flags after loads", 32'hc, fl);
    $display("reset and load tests done");
    stop_test();
  end
endmodule // tb_dcff_top
